// File: rtl/pin_function_reset_config.sv
// Pin function selection after reset, crystal pin alternates and test port pins.
`timescale 1ns/10ps
`include "pin_function_reset_config_regs.svh"
module pin_function_reset_config
    import pin_function_reset_config_pkg::*;
#(
    parameter bit FULL_FEATURE = 1'b1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration from the GPIO port logic.
    input wire logic cfg_we,
    input wire pin_cfg_t cfg_in,
    output pin_cfg_t cfg_out,
    input wire logic osc_to_core_req,
    // Peripheral side of the multiplexed pins.
    input wire logic [6:0] per_out,
    input wire logic [6:0] per_oe,
    output logic [6:0] per_in,
    output logic [6:0] gpio_in,
    // Oscillator clock routing.
    output logic osc_enable,
    output logic osc_to_core,
    output logic osc_to_pll,
    // Multiplexed pads.
    input wire logic [6:0] pad_in,
    output logic [6:0] pad_out,
    output logic [6:0] pad_oe_n,
    output logic [6:0] pad_pull_en,
    // Test port pads.
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    output logic tck_pull_down,
    output logic tms_pull_up,
    output logic tdi_pull_up,
    output logic tdo_out,
    output logic tdo_oe_n,
    output logic tdo_pull_up,
    output logic [3:0] tap_ir
);
    pin_cfg_t cfg;
    pin_cfg_t next_cfg;
    pin_cfg_t cfg_reset;
    logic [6:0] pull_map;
    logic osc_core_sel;
    logic next_osc_core_sel;

    // Reset value of the enables depends on the variant; the reduced one starts every pin on GPIO.
    always_comb begin
        cfg_reset.port_b_peripheral_enable = FULL_FEATURE ? `PIN_RESET_PER_FULL
                                                          : `PIN_RESET_PER_REDUCED;
        cfg_reset.dir = `PIN_RESET_DIR;
        cfg_reset.dout = `PIN_RESET_DOUT;
        // A plain vector lets each cell take its own bit, with no shift to truncate.
        pull_map = `PIN_RESET_PULL;
    end

    // Only a software write changes the selection, so alternates never appear alone.
    always_comb begin
        next_cfg = cfg;
        next_osc_core_sel = osc_core_sel;
        if (cfg_we) begin
            next_cfg = cfg_in;
            next_osc_core_sel = osc_to_core_req;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg <= cfg_reset;
            osc_core_sel <= 1'b0;
        end else begin
            cfg <= next_cfg;
            osc_core_sel <= next_osc_core_sel;
        end
    end

    // Reduced variant parks a peripheral-enabled pin until software has written; all its pins reset to GPIO.
    logic written;
    logic next_written;

    always_comb begin
        next_written = written | cfg_we;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            written <= 1'b0;
        end else begin
            written <= next_written;
        end
    end

    // One cell per multiplexed pin.
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
            pin_mux_cell u_cell (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .per_sel(cfg.port_b_peripheral_enable[g]),
                .parked(~FULL_FEATURE & ~written & cfg.port_b_peripheral_enable[g]),
                .gpio_dir(cfg.dir[g]),
                .gpio_dout(cfg.dout[g]),
                .reset_pull(pull_map[g]),
                .per_out(per_out[g]),
                .per_oe(per_oe[g]),
                .per_in(per_in[g]),
                .gpio_in(gpio_in[g]),
                .pad_in(pad_in[g]),
                .pad_out(pad_out[g]),
                .pad_oe_n(pad_oe_n[g]),
                .pad_pull_en(pad_pull_en[g])
            );
        end
    endgenerate

    // The oscillator runs while both crystal pins stay on their primary function.
    always_comb begin
        cfg_out = cfg;
        osc_enable = cfg.port_b_peripheral_enable[`PIN_PORT_C_BIT_ZERO]
                   & cfg.port_b_peripheral_enable[`PIN_PORT_C_BIT_ONE];
        osc_to_core = osc_enable & osc_core_sel;
        osc_to_pll = osc_enable & ~osc_core_sel;
    end

    // Test pins come from the probe, so each passes two flip-flops before use.
    logic [2:0] tsync_a;
    logic [2:0] tsync_b;
    logic tck_prev;
    logic [2:0] next_tsync_a;
    logic [2:0] next_tsync_b;
    logic next_tck_prev;

    always_comb begin
        next_tsync_a = {tck_pin, tms_pin, tdi_pin};
        next_tsync_b = tsync_a;
        next_tck_prev = tsync_b[2];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tsync_a <= 3'h0;
            tsync_b <= 3'h0;
            tck_prev <= 1'b0;
        end else begin
            tsync_a <= next_tsync_a;
            tsync_b <= next_tsync_b;
            tck_prev <= next_tck_prev;
        end
    end

    // The pad pulls are fixed; the edge detector works on the second stage only.
    logic tck_rise;
    logic tck_fall;

    always_comb begin
        tck_pull_down = 1'b1;
        tms_pull_up = 1'b1;
        tdi_pull_up = 1'b1;
        tck_rise = tsync_b[2] & ~tck_prev;
        tck_fall = ~tsync_b[2] & tck_prev;
    end

    // TAP controller, instruction shift path and bypass bit.
    tap_state_t state;
    tap_state_t next_state;
    logic [3:0] ir_sr;
    logic [3:0] next_ir_sr;
    logic [3:0] next_tap_ir;
    logic bypass;
    logic next_bypass;
    logic tms;
    logic tdi;

    always_comb begin
        tms = tsync_b[1];
        tdi = tsync_b[0];
        next_state = state;
        next_ir_sr = ir_sr;
        next_tap_ir = tap_ir;
        next_bypass = bypass;
        if (tck_rise) begin
            case (state)
                TLR: next_state = tms ? TLR : RTI;
                RTI: next_state = tms ? SEL_DR : RTI;
                SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
                CAP_DR: next_state = tms ? EX1_DR : SH_DR;
                SH_DR: next_state = tms ? EX1_DR : SH_DR;
                EX1_DR: next_state = tms ? UPD_DR : PA_DR;
                PA_DR: next_state = tms ? EX2_DR : PA_DR;
                EX2_DR: next_state = tms ? UPD_DR : SH_DR;
                UPD_DR: next_state = tms ? SEL_DR : RTI;
                SEL_IR: next_state = tms ? TLR : CAP_IR;
                CAP_IR: next_state = tms ? EX1_IR : SH_IR;
                SH_IR: next_state = tms ? EX1_IR : SH_IR;
                EX1_IR: next_state = tms ? UPD_IR : PA_IR;
                PA_IR: next_state = tms ? EX2_IR : PA_IR;
                EX2_IR: next_state = tms ? UPD_IR : SH_IR;
                UPD_IR: next_state = tms ? SEL_DR : RTI;
                default: next_state = TLR;
            endcase
            case (state)
                TLR: next_tap_ir = `TAP_IR_RESET;
                CAP_IR: next_ir_sr = `TAP_IR_CAPTURE;
                SH_IR: next_ir_sr = {tdi, ir_sr[3:1]};
                UPD_IR: next_tap_ir = ir_sr;
                CAP_DR: next_bypass = 1'b0;
                SH_DR: next_bypass = tdi;
                default: next_bypass = bypass;
            endcase
        end
    end

    // Output data and driver only move on the falling edge, a half period after shift.
    logic next_tdo_out;
    logic next_tdo_oe_n;

    always_comb begin
        next_tdo_out = tdo_out;
        next_tdo_oe_n = tdo_oe_n;
        if (tck_fall) begin
            next_tdo_oe_n = ~((state == SH_IR) || (state == SH_DR));
            next_tdo_out = (state == SH_IR) ? ir_sr[0] : bypass;
        end
        tdo_pull_up = tdo_oe_n;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= TLR;
            ir_sr <= `TAP_IR_RESET;
            tap_ir <= `TAP_IR_RESET;
            bypass <= 1'b0;
            tdo_out <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            ir_sr <= next_ir_sr;
            tap_ir <= next_tap_ir;
            bypass <= next_bypass;
            tdo_out <= next_tdo_out;
            tdo_oe_n <= next_tdo_oe_n;
        end
    end
endmodule // pin_function_reset_config

// File: rtl/pin_function_reset_config_pkg.sv
// Types shared by the pin function and test port logic.
package pin_function_reset_config_pkg;

    // Per-pin configuration written by the GPIO port logic.
    typedef struct packed {
        logic [6:0] port_b_peripheral_enable;
        logic [6:0] dir;
        logic [6:0] dout;
    } pin_cfg_t;

    // Test access port controller states, one-hot.
    typedef enum logic [15:0] {
        TLR = 16'h0001,
        RTI = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SH_DR = 16'h0010,
        EX1_DR = 16'h0020,
        PA_DR = 16'h0040,
        EX2_DR = 16'h0080,
        UPD_DR = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SH_IR = 16'h0800,
        EX1_IR = 16'h1000,
        PA_IR = 16'h2000,
        EX2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } tap_state_t;

endpackage

// File: rtl/pin_function_reset_config_regs.svh
// Constants for pin function selection, reset pin states and test port pins.
`ifndef PIN_FUNCTION_RESET_CONFIG_REGS_SVH
`define PIN_FUNCTION_RESET_CONFIG_REGS_SVH

// Number of multiplexed pins handled by this block.
`define PIN_COUNT 7
// Pin positions: port C bits 0 and 1, port B bits 3 to 7.
`define PIN_PORT_C_BIT_ZERO 0
`define PIN_PORT_C_BIT_ONE 1
`define PIN_PORT_B_BIT_THREE 2
`define PIN_PORT_B_BIT_FOUR 3
// Pull-up state of the primary function while in reset, one bit per pin.
`define PIN_RESET_PULL 7'h7c
// Peripheral-enable value after reset on the full-feature variant.
`define PIN_RESET_PER_FULL 7'h7f
// Peripheral-enable value after reset on the reduced variant.
`define PIN_RESET_PER_REDUCED 7'h00
// GPIO direction (1 is output) and data after reset.
`define PIN_RESET_DIR 7'h00
`define PIN_RESET_DOUT 7'h00
// Instruction register width and the value loaded in Capture-IR.
`define TAP_IR_WIDTH 4
`define TAP_IR_CAPTURE 4'h1
`define TAP_IR_RESET 4'hf

`endif

// File: rtl/pin_mux_cell.sv
// One multiplexed pin: input synchroniser and peripheral or GPIO routing.
`timescale 1ns/10ps
module pin_mux_cell (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Selection and GPIO settings.
    input wire logic per_sel,
    input wire logic parked,
    input wire logic gpio_dir,
    input wire logic gpio_dout,
    input wire logic reset_pull,
    // Peripheral side.
    input wire logic per_out,
    input wire logic per_oe,
    output logic per_in,
    output logic gpio_in,
    // Pad side.
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pull_en
);
    logic sync_a;
    logic sync_b;
    logic next_sync_a;
    logic next_sync_b;

    // Pad input is asynchronous to core_clk, so it passes two flip-flops.
    always_comb begin
        next_sync_a = pad_in;
        next_sync_b = sync_a;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // Reset forces the primary reset state; afterwards the enable picks the owner.
    always_comb begin
        pad_out = per_sel ? per_out : gpio_dout;
        pad_pull_en = reset_pull;
        if (sys_rst || parked) begin
            pad_oe_n = 1'b1;
        end else if (per_sel) begin
            pad_oe_n = ~per_oe;
        end else begin
            pad_oe_n = ~gpio_dir;
        end
        per_in = per_sel & ~parked & sync_b;
        gpio_in = ~per_sel & ~parked & sync_b;
    end
endmodule // pin_mux_cell

// File: tb/jtag_probe_model.sv
// Behavioural test probe with the board pulls on the test pins.
`timescale 1ns/10ps
module jtag_probe_model (
    // Clock and command from the bench.
    input wire logic core_clk,
    input wire logic start,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tms_seq,
    input wire logic [15:0] tdi_seq,
    // Test pins.
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic busy,
    output logic [15:0] cap
);
    // Outside a frame the lines are released and rest at their pull levels.
    initial begin
        {tck, tms, tdi, busy, cap} = {4'b0110, 16'h0000};
        forever begin
            @(posedge core_clk);
            if (start === 1'b1) begin
                busy <= 1'b1;
                for (int i = 0; i < nbits; i++) begin
                    tms <= tms_seq[i];
                    tdi <= tdi_seq[i];
                    repeat (6) @(posedge core_clk);
                    tck <= 1'b1;
                    // A released output reads back as the pull-up level.
                    cap[i] <= tdo_oe_n ? 1'b1 : tdo_out;
                    repeat (6) @(posedge core_clk);
                    tck <= 1'b0;
                end
                {tms, tdi, busy} <= 3'b110;
            end
        end
    end
endmodule // jtag_probe_model

// File: tb/pin_function_reset_config_checker.sv
// Concurrent checks on the pin function and test port block, bound to every instance.
`timescale 1ns/10ps
module pin_function_reset_config_checker
    import pin_function_reset_config_pkg::*;
#(
    parameter bit FULL_FEATURE = 1'b1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration and oscillator routing.
    input wire logic cfg_we,
    input wire pin_cfg_t cfg_in,
    input wire pin_cfg_t cfg_out,
    input wire logic osc_to_core_req,
    input wire logic osc_to_core,
    input wire logic osc_to_pll,
    input wire logic osc_enable,
    // Multiplexed pins.
    input wire logic [6:0] per_oe,
    input wire logic [6:0] per_in,
    input wire logic [6:0] gpio_in,
    input wire logic [6:0] pad_in,
    input wire logic [6:0] pad_out,
    input wire logic [6:0] pad_oe_n,
    // Test port.
    input wire logic tck_pin,
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    input wire logic tdo_pull_up
);
    // Peripheral-enable field, one bit per pin.
    logic [6:0] en;
    assign en = cfg_out.port_b_peripheral_enable;

    // All checks run on the core clock and rest while reset is high.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // Settings and pad levels still for four edges, long enough for the synchronisers.
    sequence s_quiet;
        ($stable(cfg_out) && $stable(pad_in)) [*4];
    endsequence

    a_reset_tristate: assert property ($fell(sys_rst) |-> $past(pad_oe_n) == 7'h7f)
        else $error("pad driven in reset");
    a_tdo_reset_off: assert property ($fell(sys_rst) |-> tdo_oe_n && tdo_pull_up)
        else $error("test output on after reset");
    a_cfg_write: assert property ((cfg_we && !sys_rst) |=> cfg_out == $past(cfg_in))
        else $error("write lost");
    a_osc_route: assert property (
        (cfg_we && !sys_rst) ##1 osc_enable
            |-> osc_to_core == $past(osc_to_core_req) && osc_to_pll == !osc_to_core)
        else $error("oscillator routing wrong");
    a_gpio_drive: assert property (
        !sys_rst |-> ((pad_oe_n ^ ~cfg_out.dir) & ~en) == 7'h00
            && ((pad_out ^ cfg_out.dout) & ~en & ~pad_oe_n) == 7'h00)
        else $error("port pin ignores direction or data");
    // The sampled reset is excluded too: the last reset edge still shows the forced tri-state.
    a_per_drive: assert property (
        (FULL_FEATURE && !sys_rst) |-> ((pad_oe_n ^ ~per_oe) & en) == 7'h00)
        else $error("peripheral enable not followed");
    a_input_route: assert property (
        s_quiet |-> ((gpio_in ^ pad_in) & ~en) == 7'h00 && (per_in & ~en) == 7'h00
            && (!FULL_FEATURE || ((per_in ^ pad_in) & en) == 7'h00))
        else $error("pad input sent to wrong owner");
    a_tdo_edge: assert property (($changed(tdo_out) || $changed(tdo_oe_n)) |-> !tck_pin)
        else $error("test output moved with test clock high");
endmodule // pin_function_reset_config_checker

// Every instance gets its own checker with its own variant setting.
bind pin_function_reset_config pin_function_reset_config_checker #(
    .FULL_FEATURE(FULL_FEATURE)
) u_checker (
    .core_clk, .sys_rst, .cfg_we, .cfg_in, .cfg_out, .osc_to_core_req, .osc_to_core,
    .osc_to_pll, .osc_enable, .per_oe, .per_in, .gpio_in, .pad_in, .pad_out, .pad_oe_n,
    .tck_pin, .tdo_out, .tdo_oe_n, .tdo_pull_up
);

// File: tb/pin_function_reset_config_tb.sv
// Self-checking bench for the pin function and test port block.
`timescale 1ns/10ps
module pin_function_reset_config_tb;
    import pin_function_reset_config_pkg::*;
    // One case: settings and peripheral drive, then pad enables, driven data, oscillator routing.
    typedef struct {
        pin_cfg_t cfg;
        logic [6:0] poe, pout, oe_n, dout;
        logic req;
        logic [2:0] osc;
    } row_t;
    row_t rows [5] = '{
        '{'{7'h7f, 7'h00, 7'h00}, 7'h05, 7'h04, 7'h7a, 7'h04, 1'b1, 3'b110},
        '{'{7'h7f, 7'h00, 7'h00}, 7'h00, 7'h00, 7'h7f, 7'h00, 1'b0, 3'b101},
        '{'{7'h7b, 7'h00, 7'h04}, 7'h7f, 7'h7f, 7'h04, 7'h7b, 1'b0, 3'b101},
        '{'{7'h7c, 7'h03, 7'h01}, 7'h00, 7'h00, 7'h7c, 7'h01, 1'b1, 3'b000},
        '{'{7'h00, 7'h55, 7'h15}, 7'h7f, 7'h00, 7'h2a, 7'h15, 1'b0, 3'b000}
    };
    logic core_clk, sys_rst, cfg_we, osc_to_core_req, start, busy;
    logic osc_enable, osc_to_core, osc_to_pll, tck_pin, tms_pin, tdi_pin;
    logic tck_pull_down, tms_pull_up, tdi_pull_up, tdo_out, tdo_oe_n, tdo_pull_up;
    logic [6:0] per_out, per_oe, per_in, gpio_in, pad_in, pad_out, pad_oe_n, pad_pull_en;
    logic [15:0] tms_seq, tdi_seq, cap;
    logic [4:0] nbits;
    logic [3:0] tap_ir;
    pin_cfg_t cfg_in, cfg_out, red_cfg;
    int n_errors = 0;
    int checks = 0;

    // Full-feature block, the reduced variant beside it, and the probe.
    pin_function_reset_config u_dut (
        .core_clk, .sys_rst, .cfg_we, .cfg_in, .cfg_out, .osc_to_core_req, .per_out, .per_oe,
        .per_in, .gpio_in, .osc_enable, .osc_to_core, .osc_to_pll, .pad_in, .pad_out, .pad_oe_n,
        .pad_pull_en, .tck_pin, .tms_pin, .tdi_pin, .tck_pull_down, .tms_pull_up, .tdi_pull_up,
        .tdo_out, .tdo_oe_n, .tdo_pull_up, .tap_ir
    );
    pin_function_reset_config #(.FULL_FEATURE(1'b0)) u_red (
        .core_clk, .sys_rst, .cfg_we, .cfg_in, .cfg_out(red_cfg), .osc_to_core_req, .per_out,
        .per_oe, .per_in(), .gpio_in(), .osc_enable(), .osc_to_core(), .osc_to_pll(), .pad_in,
        .pad_out(), .pad_oe_n(), .pad_pull_en(), .tck_pin, .tms_pin, .tdi_pin, .tck_pull_down(),
        .tms_pull_up(), .tdi_pull_up(), .tdo_out(), .tdo_oe_n(), .tdo_pull_up(), .tap_ir()
    );
    jtag_probe_model u_probe (
        .core_clk, .start, .nbits, .tms_seq, .tdi_seq, .tdo_out, .tdo_oe_n, .tck(tck_pin),
        .tms(tms_pin), .tdi(tdi_pin), .busy, .cap
    );

    // Core clock, 100 ns period.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One settings write, then wait until its effect has landed.
    task automatic drive(input row_t r);
        @(posedge core_clk);
        {cfg_in, per_oe, per_out, osc_to_core_req, cfg_we} <= {r.cfg, r.poe, r.pout, r.req, 1'b1};
        @(posedge core_clk);
        cfg_we <= 1'b0;
        @(negedge core_clk);
    endtask

    // Runs one probe frame; the bound keeps a stuck probe from hanging the run.
    task automatic jtag(input logic [4:0] n, input logic [15:0] m, input logic [15:0] d);
        int k = 0;
        @(posedge core_clk);
        {nbits, tms_seq, tdi_seq, start} <= {n, m, d, 1'b1};
        @(posedge core_clk);
        start <= 1'b0;
        repeat (2) @(posedge core_clk);
        while (busy === 1'b1 && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        chk(k >= 300, 64'h0);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic final_report;
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset, the table of settings, input routing, then a second reset and test port frames.
    initial begin
        {sys_rst, cfg_we, osc_to_core_req, start, cfg_in, per_out, per_oe, pad_in, nbits, tms_seq,
            tdi_seq} = {1'b1, 82'h0};
        @(negedge core_clk);
        chk(pad_oe_n, 7'h7f);
        chk({tdo_oe_n, tdo_pull_up}, 2'b11);
        chk({tck_pull_down, tms_pull_up, tdi_pull_up, pad_pull_en}, 10'h3fc);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk({cfg_out, osc_enable}, {7'h7f, 14'h0, 1'b1});
        chk(red_cfg, 21'h0);
        foreach (rows[i]) begin
            drive(rows[i]);
            chk(cfg_out, rows[i].cfg);
            chk(pad_oe_n, rows[i].oe_n);
            chk(pad_out & ~pad_oe_n, rows[i].dout);
            chk({osc_enable, osc_to_core, osc_to_pll}, rows[i].osc);
        end
        // Every pin now sits on its port, odd pins as inputs.
        @(posedge core_clk);
        pad_in <= 7'h2a;
        repeat (4) @(negedge core_clk);
        chk({gpio_in & 7'h2a, per_in}, {7'h2a, 7'h00});
        // A second reset with a write held high, which must not take effect.
        @(posedge core_clk);
        {sys_rst, cfg_we} <= 2'b11;
        repeat (2) @(posedge core_clk);
        {sys_rst, cfg_we} <= 2'b00;
        repeat (4) @(negedge core_clk);
        chk({cfg_out, red_cfg}, {7'h7f, 14'h0, 21'h0});
        chk(per_in, 7'h2a);
        jtag(5'd11, 16'h0306, 16'h0140);
        chk({cap[9:4], tap_ir, tdo_oe_n}, {6'h23, 4'ha, 1'b1});
        jtag(5'd5, 16'h001f, 16'h0000);
        chk(tap_ir, 4'hf);
        // Bypass scan: captures 0, then echoes the data input one bit late.
        jtag(5'd9, 16'h00c2, 16'h0050);
        chk({cap[7:3], tap_ir}, {5'h15, 4'hf});
        final_report;
    end

    // Watchdog: the run needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        final_report;
    end
endmodule // pin_function_reset_config_tb
